// [hdl/mioabe_top.sv]
// mioabe_top: address/data ports, bus-control port and two key
// wake-up ports, reached over a classic wishbone slave.
// assumes pins synchronous to clk_i; pads resolve from out/oe.
`timescale 1ns/1ns
module mioabe_top
  import mioabe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [MIOABE_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] high_in_i,
  output logic [7:0] high_out_o,
  output logic [7:0] high_oe_o,
  output logic [7:0] high_pullup_o,
  output logic high_reduced_o,
  input wire logic [7:0] low_in_i,
  output logic [7:0] low_out_o,
  output logic [7:0] low_oe_o,
  output logic [7:0] low_pullup_o,
  output logic low_reduced_o,
  input wire logic [15:0] ext_addr_i,
  input wire logic [15:0] ext_wdata_i,
  input wire logic ext_drive_i,
  output logic [15:0] ext_rdata_o,
  input wire logic [7:0] busctl_in_i,
  output logic [7:0] busctl_out_o,
  output logic [7:0] busctl_oe_o,
  input wire logic [7:0] busctl_func_out_i,
  input wire logic [7:0] busctl_func_oe_i,
  output logic [7:0] busctl_pullup_o,
  output logic busctl_reduced_o,
  output logic nonmaskable_int_in_o,
  output logic maskable_int_in_o,
  input wire logic [7:0] wakeup_j_pins_i,
  input wire logic [7:0] wakeup_h_pins_i,
  output logic wakeup_j_irq_o,
  output logic wakeup_h_irq_o
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic [7:0] high_data;
    logic [7:0] high_port_direction;
    logic [7:0] low_data;
    logic [7:0] low_port_direction;
    logic [7:0] busctl_data;
    logic [7:0] busctl_port_direction;
    logic [7:0] busctl_pin_assign_reg;
    logic [7:0] pullup_control_reg;
    logic [7:0] drive_control_reg;
    logic drive_written;
    logic [7:0] wakeup_j_edge_polarity;
    logic [7:0] wakeup_h_edge_polarity;
    logic [7:0] wk_j_en;
    logic [7:0] wk_h_en;
    logic [7:0] high_out;
    logic [7:0] high_oe;
    logic [7:0] high_pu;
    logic [7:0] low_out;
    logic [7:0] low_oe;
    logic [7:0] low_pu;
    logic [15:0] ext_rdata;
    logic [7:0] bc_out;
    logic [7:0] bc_oe;
    logic [7:0] bc_pu;
    logic [1:0] irq_in;
  } mioabe_st_t;
  mioabe_st_t st;
  mioabe_st_t next_st;

  mioabe_wake_if wj ();
  mioabe_wake_if wh ();

  mioabe_wake u_wake_j (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .w(wj.det)
  );
  mioabe_wake u_wake_h (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .w(wh.det)
  );

  logic req;
  logic wr;
  logic rd_take;
  logic periph;
  logic expanded;
  logic ab_mapped;
  logic [7:0] wbyte;
  logic [7:0] bc_dir_eff;
  logic [7:0] bc_gpio;

  assign req = cyc_i & stb_i & ~st.ack;
  assign wr = req & we_i & sel_i[0];
  assign rd_take = req & ~we_i;
  assign wbyte = dat_i[7:0];
  assign periph = (mode_i == MIOABE_PERIPH);
  assign expanded = (mode_i == MIOABE_EXPANDED);
  assign ab_mapped = ~(periph | expanded);
  // functions assigned by pin-assign override direction bits
  assign bc_gpio = ~st.busctl_pin_assign_reg & BUSCTL_DIR_MASK;
  assign bc_dir_eff = st.busctl_port_direction & bc_gpio;

  assign wj.pins = wakeup_j_pins_i;
  assign wh.pins = wakeup_h_pins_i;
  assign wj.polarity = st.wakeup_j_edge_polarity;
  assign wh.polarity = st.wakeup_h_edge_polarity;
  assign wj.enable = st.wk_j_en;
  assign wh.enable = st.wk_h_en;
  // write one to clear a wake-up flag
  assign wj.clear = (wr && adr_i == OFS_WK_J_FLAG) ? wbyte : RST_FLAG;
  assign wh.clear = (wr && adr_i == OFS_WK_H_FLAG) ? wbyte : RST_FLAG;

  always_comb begin
    next_st = st;
    next_st.ack = req;
    if (wr) begin
      unique case (adr_i)
        OFS_HIGH_DATA:
          if (ab_mapped) next_st.high_data = wbyte;
        OFS_LOW_DATA:
          if (ab_mapped) next_st.low_data = wbyte;
        OFS_HIGH_DIR:
          if (ab_mapped) next_st.high_port_direction = wbyte;
        OFS_LOW_DIR:
          if (ab_mapped) next_st.low_port_direction = wbyte;
        OFS_BUSCTL_DATA: next_st.busctl_data = wbyte;
        OFS_BUSCTL_DIR: next_st.busctl_port_direction = wbyte;
        OFS_PIN_ASSIGN: next_st.busctl_pin_assign_reg = wbyte;
        OFS_PULLUP:
          if (!periph) next_st.pullup_control_reg = wbyte;
        OFS_DRIVE:
          if (!periph && !st.drive_written) begin
            next_st.drive_control_reg = wbyte;
            next_st.drive_written = 1'b1;
          end
        OFS_WK_J_POL: next_st.wakeup_j_edge_polarity = wbyte;
        OFS_WK_H_POL: next_st.wakeup_h_edge_polarity = wbyte;
        OFS_WK_J_EN: next_st.wk_j_en = wbyte;
        OFS_WK_H_EN: next_st.wk_h_en = wbyte;
        default: ;
      endcase
    end
    if (rd_take) begin
      next_st.rdata = RD_UNMAPPED;
      unique case (adr_i)
        OFS_HIGH_DATA:
          if (ab_mapped) next_st.rdata[7:0] = (st.high_data &
            st.high_port_direction) | (high_in_i &
            ~st.high_port_direction);
        OFS_LOW_DATA:
          if (ab_mapped) next_st.rdata[7:0] = (st.low_data &
            st.low_port_direction) | (low_in_i &
            ~st.low_port_direction);
        OFS_HIGH_DIR:
          if (ab_mapped) next_st.rdata[7:0] = st.high_port_direction;
        OFS_LOW_DIR:
          if (ab_mapped) next_st.rdata[7:0] = st.low_port_direction;
        // pe1:0 always show the pin level, even as interrupt inputs
        OFS_BUSCTL_DATA: next_st.rdata[7:0] = (st.busctl_data &
          bc_dir_eff) | (busctl_in_i & ~bc_dir_eff);
        OFS_BUSCTL_DIR: next_st.rdata[7:0] = st.busctl_port_direction;
        OFS_PIN_ASSIGN: next_st.rdata[7:0] = st.busctl_pin_assign_reg;
        OFS_PULLUP:
          if (!periph) next_st.rdata[7:0] = st.pullup_control_reg;
        OFS_DRIVE:
          if (!periph) next_st.rdata[7:0] = st.drive_control_reg;
        OFS_WK_J_POL: next_st.rdata[7:0] = st.wakeup_j_edge_polarity;
        OFS_WK_H_POL: next_st.rdata[7:0] = st.wakeup_h_edge_polarity;
        OFS_WK_J_FLAG: next_st.rdata[7:0] = wj.flags;
        OFS_WK_H_FLAG: next_st.rdata[7:0] = wh.flags;
        OFS_WK_J_EN: next_st.rdata[7:0] = st.wk_j_en;
        OFS_WK_H_EN: next_st.rdata[7:0] = st.wk_h_en;
        OFS_MODE: next_st.rdata[1:0] = mode_i;
        default: ;
      endcase
    end
    // address/data ports: bus in expanded and peripheral modes, gpio in single mode
    if (ab_mapped) begin
      next_st.high_out = st.high_data;
      next_st.high_oe = st.high_port_direction;
      next_st.low_out = st.low_data;
      next_st.low_oe = st.low_port_direction;
    end else begin
      next_st.high_out = ext_drive_i ? ext_wdata_i[15:8]
                                     : ext_addr_i[15:8];
      next_st.low_out = ext_drive_i ? ext_wdata_i[7:0]
                                    : ext_addr_i[7:0];
      next_st.high_oe = {8{ext_drive_i}};
      next_st.low_oe = {8{ext_drive_i}};
    end
    next_st.ext_rdata = {high_in_i, low_in_i};
    // pullups act on input pins only
    next_st.high_pu = {8{st.pullup_control_reg[BIT_HIGH]}} &
                      ~next_st.high_oe;
    next_st.low_pu = {8{st.pullup_control_reg[BIT_LOW]}} &
                     ~next_st.low_oe;
    for (int i = 0; i < 8; i++) begin
      if (bc_gpio[i]) begin
        next_st.bc_out[i] = st.busctl_data[i];
        next_st.bc_oe[i] = bc_dir_eff[i];
      end else if (i < 2) begin
        next_st.bc_out[i] = 1'b0;
        next_st.bc_oe[i] = 1'b0;
      end else begin
        next_st.bc_out[i] = busctl_func_out_i[i];
        next_st.bc_oe[i] = busctl_func_oe_i[i];
      end
    end
    next_st.bc_pu = {8{st.pullup_control_reg[BIT_BUSCTL]}} &
                    ~next_st.bc_oe;
    next_st.irq_in = busctl_in_i[1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.high_port_direction <= RST_DIR;
      st.low_port_direction <= RST_DIR;
      st.busctl_port_direction <= RST_DIR;
      st.busctl_pin_assign_reg <= RST_PIN_ASSIGN;
      st.pullup_control_reg <= RST_PULLUP;
      st.drive_control_reg <= RST_DRIVE;
      st.drive_written <= 1'b0;
      st.wakeup_j_edge_polarity <= RST_POL;
      st.wakeup_h_edge_polarity <= RST_POL;
      st.irq_in <= 2'b11;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign high_out_o = st.high_out;
  assign high_oe_o = st.high_oe;
  assign high_pullup_o = st.high_pu;
  assign high_reduced_o = st.drive_control_reg[BIT_HIGH];
  assign low_out_o = st.low_out;
  assign low_oe_o = st.low_oe;
  assign low_pullup_o = st.low_pu;
  assign low_reduced_o = st.drive_control_reg[BIT_LOW];
  assign ext_rdata_o = st.ext_rdata;
  assign busctl_out_o = st.bc_out;
  assign busctl_oe_o = st.bc_oe;
  assign busctl_pullup_o = st.bc_pu;
  assign busctl_reduced_o = st.drive_control_reg[BIT_BUSCTL];
  assign nonmaskable_int_in_o = st.irq_in[0];
  assign maskable_int_in_o = st.irq_in[1];
  assign wakeup_j_irq_o = wj.irq;
  assign wakeup_h_irq_o = wh.irq;
endmodule : mioabe_top

// [hdl/mioabe_pkg.sv]
// mioabe_pkg: register offsets, field positions and reset values
// for the multiplexed i/o port block; shared by both design files.
package mioabe_pkg;
  localparam int MIOABE_AW = 6;
  localparam logic [5:0] OFS_HIGH_DATA = 6'h00;
  localparam logic [5:0] OFS_LOW_DATA = 6'h04;
  localparam logic [5:0] OFS_HIGH_DIR = 6'h08;
  localparam logic [5:0] OFS_LOW_DIR = 6'h0c;
  localparam logic [5:0] OFS_BUSCTL_DATA = 6'h10;
  localparam logic [5:0] OFS_BUSCTL_DIR = 6'h14;
  localparam logic [5:0] OFS_PIN_ASSIGN = 6'h18;
  localparam logic [5:0] OFS_PULLUP = 6'h1c;
  localparam logic [5:0] OFS_DRIVE = 6'h20;
  localparam logic [5:0] OFS_WK_J_POL = 6'h24;
  localparam logic [5:0] OFS_WK_H_POL = 6'h28;
  localparam logic [5:0] OFS_WK_J_FLAG = 6'h2c;
  localparam logic [5:0] OFS_WK_H_FLAG = 6'h30;
  localparam logic [5:0] OFS_WK_J_EN = 6'h34;
  localparam logic [5:0] OFS_WK_H_EN = 6'h38;
  localparam logic [5:0] OFS_MODE = 6'h3c;
  // field positions in pullup and drive control
  localparam int BIT_HIGH = 0;
  localparam int BIT_LOW = 1;
  localparam int BIT_BUSCTL = 4;
  // low two bus-control pins are input-only
  localparam logic [7:0] BUSCTL_DIR_MASK = 8'hfc;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_PIN_ASSIGN = 8'h00;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
  typedef enum logic [1:0] {
    MIOABE_SINGLE = 2'b00,
    MIOABE_EXPANDED = 2'b01,
    MIOABE_PERIPH = 2'b10
  } mioabe_mode_t;
endpackage : mioabe_pkg

// [hdl/mioabe_wake_if.sv]
// mioabe_wake_if: carries one key wake-up port between the top
// and its edge detector; all signals on the system clock.
`timescale 1ns/1ns
interface mioabe_wake_if;
  logic [7:0] pins;
  logic [7:0] polarity;
  logic [7:0] clear;
  logic [7:0] enable;
  logic [7:0] flags;
  logic irq;
  modport top (output pins, output polarity, output clear,
               output enable, input flags, input irq);
  modport det (input pins, input polarity, input clear,
               input enable, output flags, output irq);
endinterface : mioabe_wake_if

// [hdl/mioabe_wake.sv]
// mioabe_wake: per-pin edge detector with sticky flags for one
// key wake-up port. assumes pins already synchronous to clk_i.
`timescale 1ns/1ns
module mioabe_wake
  import mioabe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  mioabe_wake_if.det w
);
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] flags;
    logic irq;
  } mioabe_wake_st_t;
  mioabe_wake_st_t st;
  mioabe_wake_st_t next_st;
  logic [7:0] hit;

  // polarity bit set selects rising edge, clear selects falling
  genvar g;
  for (g = 0; g < 8; g++) begin : g_pin
    assign hit[g] = w.polarity[g] ? (w.pins[g] & ~st.prev[g])
                                  : (~w.pins[g] & st.prev[g]);
  end

  always_comb begin
    next_st = st;
    next_st.prev = w.pins;
    // a fresh edge wins over a clear in the same cycle
    next_st.flags = (st.flags & ~w.clear) | hit;
    next_st.irq = |(next_st.flags & w.enable);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.prev <= RST_FLAG;
      st.flags <= RST_FLAG;
      st.irq <= 1'b0;
    end else begin
      // first cycle out of reset may see prev=0: a spurious rising
      // hit is possible for a high pin; software clears it
      st <= next_st;
    end
  end

  assign w.flags = st.flags;
  assign w.irq = st.irq;
endmodule : mioabe_wake

// [tb/mioabe_monitor.sv]
// mioabe_monitor: bus, reset, pin and wake-up timing checks.
// assumes a wishbone master that keeps the request until ack.
`timescale 1ns/1ns
module mioabe_monitor
  import mioabe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [MIOABE_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] high_oe_o,
  input wire logic [7:0] low_oe_o,
  input wire logic [7:0] busctl_oe_o,
  input wire logic high_reduced_o,
  input wire logic low_reduced_o,
  input wire logic busctl_reduced_o,
  input wire logic [7:0] busctl_in_i,
  input wire logic nonmaskable_int_in_o,
  input wire logic maskable_int_in_o,
  input wire logic [7:0] wakeup_j_pins_i,
  input wire logic wakeup_j_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic unm;
  logic drv_done;
  assign unm = ((mode_i == 2'h1 || mode_i == 2'h2) && adr_i <= OFS_LOW_DIR)
    || (mode_i == 2'h2 && (adr_i == OFS_PULLUP || adr_i == OFS_DRIVE));
  // a write blocked in peripheral mode does not use up the one write
  always_ff @(posedge clk_i) begin
    if (rst_i) drv_done <= 1'b0;
    else if (ack_o && we_i && sel_i[0] && adr_i == OFS_DRIVE
             && mode_i != 2'h2) drv_done <= 1'b1;
  end
  a_ack_after_take: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
  a_ack_one_pulse: assert property (
    ack_o |=> !ack_o) else $error("ack held too long");
  a_reset_all_inputs: assert property (
    $fell(rst_i) |-> {high_oe_o, low_oe_o, busctl_oe_o} == 24'h000000)
    else $error("pin driven right after reset");
  a_busctl_low_input: assert property (
    busctl_oe_o[1:0] == 2'b00) else $error("input-only pin driven");
  a_int_pins_follow: assert property (
    !rst_i |=> {maskable_int_in_o, nonmaskable_int_in_o}
      == $past(busctl_in_i[1:0])) else $error("interrupt input lost");
  a_unmapped_read_zero: assert property (
    ack_o && !we_i && unm |-> dat_o == 32'h00000000)
    else $error("unmapped register read back");
  a_drive_write_once: assert property (
    drv_done |=> $stable({high_reduced_o, low_reduced_o, busctl_reduced_o}))
    else $error("drive control changed twice");
  a_wake_irq_cause: assert property (
    $rose(wakeup_j_irq_o) |-> ack_o || $past(ack_o) || $past(rst_i, 2)
      || $past(wakeup_j_pins_i) != $past(wakeup_j_pins_i, 2))
    else $error("wake-up irq without edge");
  c_write: cover property (ack_o && we_i);
  c_wake: cover property ($rose(wakeup_j_irq_o));
  c_unmapped: cover property (ack_o && !we_i && unm);
endmodule : mioabe_monitor

bind mioabe_top mioabe_monitor i_mioabe_monitor (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_o, .ack_o, .mode_i, .high_oe_o,
  .low_oe_o, .busctl_oe_o, .high_reduced_o, .low_reduced_o,
  .busctl_reduced_o, .busctl_in_i, .nonmaskable_int_in_o,
  .maskable_int_in_o, .wakeup_j_pins_i, .wakeup_j_irq_o);

// [tb/mioabe_board.sv]
// mioabe_board: board circuitry on one eight-pin port.
// assumes oe high means the device drives; undriven pads wander.
`timescale 1ns/1ns
module mioabe_board (
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] drv_en_i,
  output logic [7:0] pad_o
);
  // a floating pad must never read back a steady value
  logic [7:0] flt = 8'h5a;
  always @(posedge clk_i) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) pad_o[i] = out_i[i];
      else if (drv_en_i[i]) pad_o[i] = drv_i[i];
      else if (pullup_i[i]) pad_o[i] = 1'b1;
      else pad_o[i] = flt[i];
    end
  end
endmodule : mioabe_board

// [tb/mioabe_top_bench.sv]
// mioabe_top_bench: random and corner tests of the port block.
// assumes the monitor is bound in and one board model per address/data and bus-control port.
`timescale 1ns/1ns
module mioabe_top_bench;
  import mioabe_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ext_drive_i = 1'b0;
  logic [5:0] adr_i = 6'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [1:0] mode_i = 2'h0;
  logic [7:0] high_in_i, high_out_o, high_oe_o, high_pullup_o, low_in_i;
  logic [7:0] low_out_o, low_oe_o, low_pullup_o, busctl_in_i, busctl_out_o;
  logic [7:0] busctl_oe_o, busctl_pullup_o, d, m, v, em, f, r;
  logic [7:0] busctl_func_out_i = 8'h00, busctl_func_oe_i = 8'h00;
  logic ack_o, high_reduced_o, low_reduced_o, busctl_reduced_o;
  logic nonmaskable_int_in_o, maskable_int_in_o, wj, wh;
  logic [15:0] ext_addr_i = 16'h0, ext_wdata_i = 16'h0, ext_rdata_o;
  logic [7:0] wk [2] = '{8'h00, 8'h00};
  logic [7:0] pv [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] pe [3] = '{8'h00, 8'h00, 8'h00};
  localparam logic [5:0] DOFS [3] = '{OFS_HIGH_DATA, OFS_LOW_DATA,
    OFS_BUSCTL_DATA};
  localparam logic [5:0] ROFS [3] = '{OFS_HIGH_DIR, OFS_LOW_DIR,
    OFS_BUSCTL_DIR};
  int err_total = 0, n_tests = 0, p;
  initial forever #50 clk_i = ~clk_i;
  mioabe_board i_mioabe_board_hi (.clk_i, .out_i(high_out_o),
    .oe_i(high_oe_o), .pullup_i(high_pullup_o), .drv_i(pv[0]),
    .drv_en_i(pe[0]), .pad_o(high_in_i));
  mioabe_board i_mioabe_board_lo (.clk_i, .out_i(low_out_o),
    .oe_i(low_oe_o), .pullup_i(low_pullup_o), .drv_i(pv[1]),
    .drv_en_i(pe[1]), .pad_o(low_in_i));
  mioabe_board i_mioabe_board_bc (.clk_i, .out_i(busctl_out_o),
    .oe_i(busctl_oe_o), .pullup_i(busctl_pullup_o), .drv_i(pv[2]),
    .drv_en_i(pe[2]), .pad_o(busctl_in_i));
  mioabe_top i_mioabe_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .mode_i, .high_in_i, .high_out_o,
    .high_oe_o, .high_pullup_o, .high_reduced_o, .low_in_i, .low_out_o,
    .low_oe_o, .low_pullup_o, .low_reduced_o, .ext_addr_i, .ext_wdata_i,
    .ext_drive_i, .ext_rdata_o, .busctl_in_i, .busctl_out_o, .busctl_oe_o,
    .busctl_func_out_i, .busctl_func_oe_i, .busctl_pullup_o,
    .busctl_reduced_o, .nonmaskable_int_in_o, .maskable_int_in_o,
    .wakeup_j_pins_i(wk[0]), .wakeup_h_pins_i(wk[1]),
    .wakeup_j_irq_o(wj), .wakeup_h_irq_o(wh));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] x);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, w, a, 4'h1};
    dat_i <= {24'h0, x};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (ack_o !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask : bus
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask : rdchk
  initial begin
    void'($urandom(21320));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // busctl data reads the floating pads while every pin is an input
    for (int a = 8; a < 60; a += 4) begin
      if (a != int'(OFS_BUSCTL_DATA)) rdchk(6'(a), 8'h00);
    end
    @(negedge clk_i);
    chk({high_oe_o, low_oe_o, busctl_oe_o}, 24'h0);
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      p = k % 3;
      {d, m, v} = 24'($urandom);
      if (k < 6) m = (k < 3) ? 8'hff : 8'h00;
      em = (p == 2) ? (m & BUSCTL_DIR_MASK) : m;
      @(posedge clk_i);
      pv[p] <= v;
      pe[p] <= ~em;
      bus(1'b1, DOFS[p], d);
      bus(1'b1, ROFS[p], m);
      rdchk(DOFS[p], (d & em) | (v & ~em));
      @(negedge clk_i);
      chk(p == 0 ? high_oe_o : p == 1 ? low_oe_o : busctl_oe_o, em);
    end
    $display("test direction done");
    @(posedge clk_i);
    pe <= '{8'h00, 8'h00, 8'h00};
    bus(1'b1, OFS_HIGH_DIR, 8'h00);
    bus(1'b1, OFS_LOW_DIR, 8'h00);
    bus(1'b1, OFS_PULLUP, 8'h03);
    rdchk(OFS_HIGH_DATA, 8'hff);
    rdchk(OFS_LOW_DATA, 8'hff);
    @(negedge clk_i);
    chk({high_pullup_o, low_pullup_o, busctl_pullup_o}, 24'hffff00);
    $display("test pullup done");
    for (int md = 1; md < 3; md++) begin
      mode_i <= 2'(md);
      for (int a = 0; a < 16; a += 4) begin
        bus(1'b1, 6'(a), 8'hff);
        rdchk(6'(a), 8'h00);
      end
    end
    bus(1'b1, OFS_DRIVE, 8'h13);
    rdchk(OFS_DRIVE, 8'h00);
    rdchk(OFS_PULLUP, 8'h00);
    mode_i <= MIOABE_SINGLE;
    rdchk(OFS_HIGH_DIR, 8'h00);
    rdchk(OFS_LOW_DIR, 8'h00);
    bus(1'b1, OFS_DRIVE, 8'h13);
    bus(1'b1, OFS_DRIVE, 8'h00);
    rdchk(OFS_DRIVE, 8'h13);
    @(negedge clk_i);
    chk({high_reduced_o, low_reduced_o, busctl_reduced_o}, 3'h7);
    @(posedge clk_i);
    mode_i <= MIOABE_EXPANDED;
    ext_drive_i <= 1'b1;
    ext_wdata_i <= 16'($urandom);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({high_oe_o, low_oe_o}, 16'hffff);
    chk({high_out_o, low_out_o}, ext_wdata_i);
    chk(ext_rdata_o, ext_wdata_i);
    @(posedge clk_i);
    mode_i <= MIOABE_SINGLE;
    ext_drive_i <= 1'b0;
    $display("test modes done");
    for (int k = 0; k < 4; k++) begin
      {d, m, v, f, r} = 40'({$urandom, $urandom});
      busctl_func_out_i <= r;
      busctl_func_oe_i <= v;
      pv[2] <= v;
      pe[2] <= 8'hff;
      bus(1'b1, OFS_BUSCTL_DIR, m);
      bus(1'b1, OFS_BUSCTL_DATA, d);
      bus(1'b1, OFS_PIN_ASSIGN, f);
      rdchk(OFS_PIN_ASSIGN, f);
      @(negedge clk_i);
      em = ((f & v) | (~f & m)) & 8'hfc;
      chk(busctl_oe_o, em);
      chk(busctl_out_o & em, ((f & r) | (~f & d)) & em);
      chk({maskable_int_in_o, nonmaskable_int_in_o}, v[1:0]);
      bus(1'b0, OFS_BUSCTL_DATA, 8'h00);
      chk(q[1:0], v[1:0]);
    end
    $display("test busctl done");
    for (int k = 0; k < 6; k++) begin
      p = k % 2;
      {d, m, v} = 24'($urandom);
      if (k < 2) v = ~m;
      @(posedge clk_i);
      wk[p] <= m;
      bus(1'b1, OFS_WK_J_POL + 6'(4 * p), d);
      bus(1'b1, OFS_WK_J_EN + 6'(4 * p), 8'hff);
      bus(1'b1, OFS_WK_J_FLAG + 6'(4 * p), 8'hff);
      wk[p] <= v;
      em = (~m & v & d) | (m & ~v & ~d);
      rdchk(OFS_WK_J_FLAG + 6'(4 * p), em);
      @(negedge clk_i);
      chk(p == 0 ? wj : wh, |em);
      bus(1'b1, OFS_WK_J_EN + 6'(4 * p), 8'h00);
      @(negedge clk_i);
      chk(p == 0 ? wj : wh, 1'b0);
      bus(1'b1, OFS_WK_J_FLAG + 6'(4 * p), 8'hff);
      rdchk(OFS_WK_J_FLAG + 6'(4 * p), 8'h00);
    end
    $display("test wakeup done");
    conclude();
  end
endmodule : mioabe_top_bench
